/* shared/spi_nvm_pkg.sv */
/*
  Shared constants for the serial nonvolatile memory slave: opcodes,
  status bit layout, reset values and array geometry.
  Assumes the array is byte wide and addressed with 18 bits.
*/
package spi_nvm_pkg;

  localparam int ADDR_W = 18;
  localparam int ADDR_BYTES = 3;
  localparam int MEM_DEPTH = 262144;

  // Command opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FSTRD = 8'h0b;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_RDID = 8'h9f;

  // Status register field positions
  localparam int SR_WEL_BIT = 1;
  localparam int SR_BP0_BIT = 2;
  localparam int SR_BP1_BIT = 3;
  localparam int SR_FIXED1_BIT = 6;
  localparam int SR_GUARD_BIT = 7;

  // Reset values of the writable status fields
  localparam logic SR_WEL_RST = 1'b0;
  localparam logic [1:0] SR_BP_RST = 2'h0;
  localparam logic SR_GUARD_RST = 1'b0;

  // Frame phases
  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_DATA,
    PH_IGNORE
  } phase_e;

endpackage

/* rtl/nvm_array.sv */
/*
  Byte wide storage array with one write port and a registered read port.
  Assumes the caller holds the address stable for the cycle of a read strobe.
*/
`timescale 1ns/1ns
module nvm_array
  import spi_nvm_pkg::*;
(
  input wire logic clk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  input wire logic re_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem [0:MEM_DEPTH-1];
  logic [7:0] rdata_reg;

  // Write and registered read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_reg <= mem[addr_i];
    end
  end

  assign rdata_o = rdata_reg;

endmodule

/* rtl/spi_nvm_slave.sv */
/*
  Serial slave front end of a byte addressed nonvolatile memory.
  All pins are oversampled by ref_clk_i; SCK must stay at or below an eighth
  of the reference rate so that every SCK level lasts several samples.
*/
`timescale 1ns/1ns
module spi_nvm_slave
  import spi_nvm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_o,
  output logic mode3_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic sck_prev_reg;
  logic cs_prev_reg;
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic hold_n_s;
  logic wp_n_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  // Two flip-flops on every pin before use
  always_ff @(posedge ref_clk_i) begin
    pin_meta_reg <= {sck_i, cs_n_i, si_i, hold_n_i, wp_n_i};
    pin_sync_reg <= pin_meta_reg;
  end

  assign {sck_s, cs_n_s, si_s, hold_n_s, wp_n_s} = pin_sync_reg;

  // Previous levels; select level frozen while held and selected, SCK level always follows the pin
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      if (hold_n_s || cs_n_s) begin
        cs_prev_reg <= cs_n_s;
      end
    end
  end

  // SCK edges act only while selected and not held; select fall needs hold high, select rise does not
  assign sck_rise = sck_s && !sck_prev_reg && !cs_n_s && !cs_prev_reg && hold_n_s;
  assign sck_fall = !sck_s && sck_prev_reg && !cs_n_s && !cs_prev_reg && hold_n_s;
  assign cs_fall = !cs_n_s && cs_prev_reg && hold_n_s;
  assign cs_rise = cs_n_s && !cs_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // Frame decoding

  phase_e phase_reg;
  logic [7:0] cmd_reg;
  logic [2:0] bit_cnt_reg;
  logic [1:0] addr_cnt_reg;
  logic [7:0] shift_in_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic wel_reg;
  logic [1:0] bp_reg;
  logic guard_pin_enable_bit_reg;
  logic wel_drop_reg;
  logic [7:0] shift_out_reg;
  logic out_src_sr_reg;
  logic [7:0] byte_in;
  logic byte_done;
  logic is_read;
  logic mem_we;
  logic mem_re;
  logic fetch_reg;
  logic [7:0] mem_rdata;
  logic [7:0] status;

  // Incoming byte, MSB first, sampled at SCK rise
  assign byte_in = {shift_in_reg[6:0], si_s};
  assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);
  assign is_read = (cmd_reg == OP_READ) || (cmd_reg == OP_FSTRD);

  // Status byte as read back; unused bits fixed
  always_comb begin
    status = 8'h00;
    status[SR_WEL_BIT] = wel_reg;
    status[SR_BP0_BIT] = bp_reg[0];
    status[SR_BP1_BIT] = bp_reg[1];
    status[SR_FIXED1_BIT] = 1'b1;
    status[SR_GUARD_BIT] = guard_pin_enable_bit_reg;
  end

  // Bit counter and shift register restart at every selection
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || cs_fall) begin
      bit_cnt_reg <= 3'h0;
      shift_in_reg <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_in_reg <= byte_in;
    end
  end

  // Mode from SCK level at selection
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mode3_o <= 1'b0;
    end else if (cs_fall) begin
      mode3_o <= sck_s;
    end
  end

  // Phase machine: opcode, address, optional dummy, data
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || cs_n_s) begin
      phase_reg <= PH_OPCODE;
      cmd_reg <= 8'h00;
      addr_cnt_reg <= 2'h0;
    end else if (byte_done) begin
      unique case (phase_reg)
        PH_OPCODE: begin
          cmd_reg <= byte_in;
          unique case (byte_in)
            OP_READ, OP_FSTRD, OP_WRITE: phase_reg <= PH_ADDR;
            OP_RDSR, OP_WRSR: phase_reg <= PH_DATA;
            OP_WREN, OP_WRDI, OP_SLEEP, OP_RDID: phase_reg <= PH_IGNORE;
            default: phase_reg <= PH_IGNORE; // Unknown opcode dropped
          endcase
        end
        PH_ADDR: begin
          addr_cnt_reg <= addr_cnt_reg + 2'h1;
          if (addr_cnt_reg == 2'(ADDR_BYTES - 1)) begin
            phase_reg <= (cmd_reg == OP_FSTRD) ? PH_DUMMY : PH_DATA;
          end
        end
        PH_DUMMY: phase_reg <= PH_DATA;
        PH_DATA: phase_reg <= (cmd_reg == OP_WRSR) ? PH_IGNORE : PH_DATA;
        PH_IGNORE: phase_reg <= PH_IGNORE;
      endcase
    end
  end

  // Address: low 18 bits kept, upper 6 shifted out; advances per byte
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      addr_reg <= '0;
    end else if (byte_done && phase_reg == PH_ADDR) begin
      addr_reg <= {addr_reg[ADDR_W-9:0], byte_in};
    end else if (mem_we || fetch_reg) begin
      addr_reg <= addr_reg + 18'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array access

  // Write at the last bit of each data byte
  assign mem_we = byte_done && (phase_reg == PH_DATA) && (cmd_reg == OP_WRITE) && wel_reg;

  // Read request when address, dummy or previous data byte completes
  assign mem_re = byte_done && is_read &&
                  ((phase_reg == PH_ADDR && addr_cnt_reg == 2'(ADDR_BYTES - 1) && cmd_reg == OP_READ) ||
                   phase_reg == PH_DUMMY || phase_reg == PH_DATA);

  // Fetch one cycle later, once a freshly loaded address has settled
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fetch_reg <= 1'b0;
    end else begin
      fetch_reg <= mem_re;
    end
  end

  nvm_array u_array (
    .clk_i(ref_clk_i),
    .addr_i(addr_reg),
    .we_i(mem_we),
    .wdata_i(byte_in),
    .re_i(fetch_reg),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status register

  // Write enable latch; set by its opcode, dropped at deselect after writes
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wel_reg <= SR_WEL_RST;
      wel_drop_reg <= 1'b0;
    end else if (cs_rise) begin
      if (wel_drop_reg) begin
        wel_reg <= 1'b0;
      end
      wel_drop_reg <= 1'b0;
    end else if (byte_done && phase_reg == PH_OPCODE) begin
      if (byte_in == OP_WREN) begin
        wel_reg <= 1'b1;
      end
      wel_drop_reg <= (byte_in == OP_WRDI) || (byte_in == OP_WRSR) || (byte_in == OP_WRITE);
    end
  end

  // Status write, refused by the protect pin when guarded
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bp_reg <= SR_BP_RST;
      guard_pin_enable_bit_reg <= SR_GUARD_RST;
    end else if (byte_done && phase_reg == PH_DATA && cmd_reg == OP_WRSR && wel_reg &&
                 !(guard_pin_enable_bit_reg && !wp_n_s)) begin
      bp_reg <= {byte_in[SR_BP1_BIT], byte_in[SR_BP0_BIT]};
      guard_pin_enable_bit_reg <= byte_in[SR_GUARD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial output

  // Source of the next output byte
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      out_src_sr_reg <= 1'b0;
    end else begin
      out_src_sr_reg <= (cmd_reg == OP_RDSR);
    end
  end

  // Shifted out on SCK fall, loaded at byte boundaries
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || cs_n_s) begin
      shift_out_reg <= 8'h00;
    end else if (sck_fall && phase_reg == PH_DATA && (is_read || cmd_reg == OP_RDSR)) begin
      if (bit_cnt_reg == 3'h0) begin
        shift_out_reg <= out_src_sr_reg ? status : mem_rdata;
      end else begin
        shift_out_reg <= {shift_out_reg[6:0], 1'b0};
      end
    end
  end

  // Drive only while returning data, never deselected or held
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || cs_n_s || !hold_n_s) begin
      so_oe_o <= 1'b0;
    end else if (sck_fall && phase_reg == PH_DATA && (is_read || cmd_reg == OP_RDSR)) begin
      so_oe_o <= 1'b1;
    end
  end

  assign so_o = shift_out_reg[7];

endmodule

/* testbench/spi_nvm_slave_properties.sv */
/* Timing checks on the serial slave pins.
   Assumes ref_clk_i oversamples every pin through a two stage synchroniser. */
`timescale 1ns/1ns
module spi_nvm_slave_properties (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic mode3_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////
  chk_cs_high_tristate: assert property (cs_n_i [*4] |-> !so_oe_o)
    else $error("output enabled while deselected");
  chk_hold_low_tristate: assert property (!hold_n_i [*4] |-> !so_oe_o)
    else $error("output enabled during hold");
  chk_so_steady_high: assert property ((sck_i && so_oe_o) [*5] |-> $stable(so_o))
    else $error("serial output moved while clock high");
  chk_oe_after_fall: assert property ($rose(so_oe_o) |-> !sck_i)
    else $error("output enabled away from a clock fall");
  chk_oe_needs_select: assert property ($rose(so_oe_o) |-> !cs_n_i && !$past(cs_n_i, 4) && hold_n_i)
    else $error("output enabled without selection");
  chk_mode_pick: assert property ($fell(cs_n_i) ##0 (hold_n_i && !cs_n_i && $stable(sck_i)) [*4]
    |-> mode3_o == sck_i)
    else $error("wrong mode picked at selection");
  chk_mode_held_idle: assert property (cs_n_i [*5] |=> $stable(mode3_o))
    else $error("mode changed while deselected");
  chk_hold_freezes_so: assert property ((!hold_n_i && !cs_n_i) [*4] |=> $stable(so_o))
    else $error("serial output moved during hold");
endmodule

/* testbench/spi_master_model.sv */
/* Serial master model: frames of bytes, mode 0 or 3, optional hold pulse.
   Assumes clk_i is the slave's reference clock; pins move on its falling edge. */
`timescale 1ns/1ns
module spi_master_model (
  input wire logic clk_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  logic flip = 1'b0;
  logic oe_seen = 1'b0;
  logic [7:0] rx[$];
  // Released output reads a level that changes every cycle
  always @(posedge clk_i) flip <= ~flip;
  wire miso = so_oe_i ? so_i : flip;
  always @(negedge clk_i) if (!cs_n_o && so_oe_i) oe_seen = 1'b1;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // One selection per command, bytes msb first, sampled before each rise
  task automatic frame(input logic m3, input logic [7:0] tx[$], input int hold_bit);
    logic [7:0] q;
    rx.delete();
    oe_seen = 1'b0;
    sck_o = m3; // Idle level picks the mode
    wt(4);
    cs_n_o = 1'b0; // Fresh fall per opcode
    wt(4);
    foreach (tx[i]) begin
      for (int b = 7; b >= 0; b--) begin
        sck_o = 1'b0;
        si_o = tx[i][b];
        wt(4);
        if (i * 8 + 7 - b == hold_bit) begin
          hold_n_o = 1'b0; // Hold moves with clock low
          wt(4);
          repeat (2) begin
            si_o = ~si_o;
            sck_o = 1'b1;
            wt(4);
            sck_o = 1'b0;
            wt(4);
          end
          hold_n_o = 1'b1;
          wt(4);
        end
        q[b] = miso;
        sck_o = 1'b1;
        wt(4);
      end
      rx.push_back(q);
    end
    if (!m3) begin
      sck_o = 1'b0;
      wt(4);
    end
    cs_n_o = 1'b1; // Deselect between commands
    si_o = ~si_o;
    wt(6);
  endtask
endmodule

/* testbench/tb_spi_nvm_slave.sv */
/* Self-checking bench for the serial memory slave.
   Assumes the master model drives the link; the bench drives reset and protect. */
`timescale 1ns/1ns
module tb_spi_nvm_slave;
  import spi_nvm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wp_n_i = 1'b1;
  logic sck, cs_n, si, hold_n, so, so_oe, mode3;
  int num_errors = 0;
  int n_tests = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  spi_nvm_slave i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe), .mode3_o(mode3));
  spi_master_model i_m (.clk_i(ref_clk_i), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
    .so_i(so), .so_oe_i(so_oe));
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic rdsr(input logic [7:0] exp);
    i_m.frame(0, {OP_RDSR, 8'h00}, -1);
    chk8("status", exp, i_m.rx[1]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Write across the top of the array, then a write without enable
  task automatic t_write_wrap;
    i_m.frame(0, {OP_WREN}, -1);
    i_m.frame(0, {OP_WRITE, 8'h03, 8'hff, 8'hff, 8'h5a, 8'hc3}, -1);
    i_m.frame(0, {OP_WRITE, 8'h00, 8'h00, 8'h00, 8'h77}, -1);
    i_m.frame(0, {OP_READ, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00}, -1);
    chk8("read_top", 8'h5a, i_m.rx[4]);
    chk8("read_wrap", 8'hc3, i_m.rx[5]);
    chk8("mode0", 8'h00, {7'h0, mode3});
  endtask
  // Fast read in mode 3
  task automatic t_mode3;
    i_m.frame(1, {OP_FSTRD, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, -1);
    chk8("fast_read", 8'hc3, i_m.rx[5]);
    i_m.frame(1, {OP_FSTRD, 8'h03, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00}, -1);
    chk8("fast_top", 8'h5a, i_m.rx[5]);
    chk8("fast_next", 8'hc3, i_m.rx[6]);
    chk8("mode3", 8'h01, {7'h0, mode3});
  endtask
  // Status writes with and without the protect pin
  task automatic t_status;
    rdsr(8'h40);
    i_m.frame(0, {OP_WREN}, -1);
    i_m.frame(0, {OP_WRSR, 8'h8c}, -1);
    rdsr(8'hcc);
    wp_n_i = 1'b0;
    i_m.frame(0, {OP_WREN}, -1);
    i_m.frame(0, {OP_WRSR, 8'h00}, -1);
    rdsr(8'hcc);
    wp_n_i = 1'b1;
    i_m.frame(0, {OP_WREN}, -1);
    rdsr(8'hce);
    i_m.frame(0, {OP_WRDI}, -1);
    rdsr(8'hcc);
    i_m.frame(0, {OP_WREN}, -1);
    i_m.frame(0, {OP_WRSR, 8'h00}, -1);
    rdsr(8'h40);
  endtask
  // Unknown opcode followed by a read pattern
  task automatic t_bad_op;
    i_m.frame(0, {8'hff, OP_READ, 8'h00, 8'h00, 8'h00, 8'h00}, -1);
    chk8("bad_op_oe", 8'h00, {7'h0, i_m.oe_seen});
    chk8("mode0_again", 8'h00, {7'h0, mode3});
    i_m.frame(0, {OP_READ, 8'h00, 8'h00, 8'h00, 8'h00}, -1);
    chk8("read_oe", 8'h01, {7'h0, i_m.oe_seen});
    chk8("idle_oe", 8'h00, {7'h0, so_oe});
  endtask
  // Hold with clock and data churn inside the address
  task automatic t_hold;
    i_m.frame(0, {OP_READ, 8'h00, 8'h00, 8'h00, 8'h00}, 12);
    chk8("hold_read", 8'hc3, i_m.rx[4]);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    srst_i = 1'b0;
    t_write_wrap();
    t_mode3();
    t_status();
    t_bad_op();
    t_hold();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    num_errors++;
    tally_and_finish();
  end
endmodule
bind spi_nvm_slave spi_nvm_slave_properties i_props (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .sck_i(sck_i),
  .cs_n_i(cs_n_i), .si_i(si_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .mode3_o(mode3_o));
